// ---- common/dbc_pkg.sv ----
// constants shared by the debug interrupt and reset/boot control block
package dbc_pkg;
  // ----------------------------------------------------------------------
  // clock and link framing
  // ----------------------------------------------------------------------
  localparam int CORE_CLK_MHZ = 100;
  localparam int LINK_BITS = 8;
  localparam logic [3:0] LINK_CNT_LAST = 4'h7;
  localparam logic [3:0] LINK_CNT_ZERO = 4'h0;
  localparam logic [7:0] WORD_ZERO = 8'h00;
  // ----------------------------------------------------------------------
  // monitor commands
  // ----------------------------------------------------------------------
  localparam logic [7:0] CMD_RUN = 8'h01;
  // ----------------------------------------------------------------------
  // processor control register fields
  // ----------------------------------------------------------------------
  localparam int CTRL_W = 24;
  localparam int CTRL_DBG_EN_BIT = 9;
  localparam logic DBG_EN_RST = 1'b1;
  // ----------------------------------------------------------------------
  // data memory and the monitor scratch area at its top
  // ----------------------------------------------------------------------
  localparam int DMEM_AW = 12;
  localparam int MON_WORDS = 32;
  localparam logic [11:0] MON_BASE = 12'hFE0;
  // ----------------------------------------------------------------------
  // control port formats
  // ----------------------------------------------------------------------
  localparam logic FMT_TWO_WIRE = 1'b0;
  localparam logic FMT_SPI = 1'b1;
  localparam int NUM_IRQ = 4;
  // ----------------------------------------------------------------------
  // execution states
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    DBC_RUN = 2'b00,
    DBC_MON = 2'b01
  } dbc_state_e;
endpackage

// ---- core/dbc_core.sv ----
// debug interrupt, debug link and reset/boot control
`timescale 1ns/1ps
module dbc_core (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic debug_link_clock_in,
  input wire logic debug_link_data_in,
  output logic debug_link_data_out,
  output logic debug_link_data_oe_out,
  input wire logic trap_exec_in,
  input wire logic interrupt_return_op_in,
  input wire logic ctrl_wr_in,
  input wire logic [dbc_pkg::CTRL_W-1:0] ctrl_wr_data_in,
  input wire logic global_maskable_irq_enable_in,
  input wire logic [dbc_pkg::NUM_IRQ-1:0] irq_lines_in,
  input wire logic cmd_take_in,
  input wire logic reply_wr_in,
  input wire logic [7:0] reply_data_in,
  input wire logic dmem_access_in,
  input wire logic [dbc_pkg::DMEM_AW-1:0] dmem_addr_in,
  input wire logic boot_pin_in,
  input wire logic chip_select_n_in,
  input wire logic boot_done_in,
  input wire logic format_wr_in,
  input wire logic format_data_in,
  output logic debug_irq_out,
  output logic debug_irq_enable_out,
  output logic in_monitor_out,
  output logic cmd_valid_out,
  output logic [7:0] cmd_data_out,
  output logic run_cmd_out,
  output logic [dbc_pkg::NUM_IRQ-1:0] maskable_irq_out,
  output logic mon_area_hit_out,
  output logic boot_active_out,
  output logic port_format_bit_out,
  output logic tx_enable_out,
  output logic scp_enable_out,
  output logic alternate_clock_input_enable_out,
  output logic dac_mute_out,
  output logic dac_recal_out
);
  // ----------------------------------------------------------------------
  // link domain: receive and transmit shifters
  // ----------------------------------------------------------------------
  logic [7:0] rx_shift_reg;
  logic [7:0] rx_word_reg;
  logic [3:0] rx_cnt_reg;
  logic rx_tgl_reg;
  logic [7:0] tx_shift_reg;
  logic [3:0] tx_cnt_reg;
  logic tx_busy_reg;
  logic rep_s1_reg;
  logic rep_s2_reg;
  logic rep_seen_reg;
  logic [7:0] reply_hold_reg;
  logic reply_tgl_reg;
  logic tx_start;
  // a pending reply starts at once; the host is only clocking to fetch it
  assign tx_start = !tx_busy_reg && (rep_s2_reg != rep_seen_reg);

  // host bits are sampled on the rising link clock while we are not talking
  always_ff @(posedge debug_link_clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rx_shift_reg <= dbc_pkg::WORD_ZERO;
      rx_word_reg <= dbc_pkg::WORD_ZERO;
      rx_cnt_reg <= dbc_pkg::LINK_CNT_ZERO;
      rx_tgl_reg <= 1'b0;
    end else if (tx_busy_reg || tx_start) begin
      rx_cnt_reg <= dbc_pkg::LINK_CNT_ZERO; // reply fetch clocks never form a command
    end else begin
      rx_shift_reg <= {rx_shift_reg[6:0], debug_link_data_in};
      if (rx_cnt_reg == dbc_pkg::LINK_CNT_LAST) begin
        rx_cnt_reg <= dbc_pkg::LINK_CNT_ZERO;
        rx_word_reg <= {rx_shift_reg[6:0], debug_link_data_in};
        rx_tgl_reg <= ~rx_tgl_reg; // word stays put until the next full byte
      end else begin
        rx_cnt_reg <= rx_cnt_reg + 4'h1;
      end
    end
  end

  // reply toggle crosses in by two flops; the held word is stable by then
  always_ff @(posedge debug_link_clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rep_s1_reg <= 1'b0;
      rep_s2_reg <= 1'b0;
    end else begin
      rep_s1_reg <= reply_tgl_reg;
      rep_s2_reg <= rep_s1_reg;
    end
  end

  // device drives the data line for one byte, msb first
  always_ff @(posedge debug_link_clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tx_shift_reg <= dbc_pkg::WORD_ZERO;
      tx_cnt_reg <= dbc_pkg::LINK_CNT_ZERO;
      tx_busy_reg <= 1'b0;
      rep_seen_reg <= 1'b0;
    end else if (tx_busy_reg) begin
      tx_shift_reg <= {tx_shift_reg[6:0], 1'b0};
      tx_cnt_reg <= tx_cnt_reg + 4'h1;
      if (tx_cnt_reg == dbc_pkg::LINK_CNT_LAST) begin
        tx_busy_reg <= 1'b0;
      end
    end else if (tx_start) begin
      rep_seen_reg <= rep_s2_reg;
      tx_shift_reg <= reply_hold_reg;
      tx_cnt_reg <= dbc_pkg::LINK_CNT_ZERO;
      tx_busy_reg <= 1'b1;
    end
  end

  assign debug_link_data_out = tx_shift_reg[7];
  assign debug_link_data_oe_out = tx_busy_reg;

  // ----------------------------------------------------------------------
  // core domain: pin and toggle synchronisers
  // ----------------------------------------------------------------------
  logic cmd_s1_reg;
  logic cmd_s2_reg;
  logic cmd_s3_reg;
  logic boot_s1_reg;
  logic boot_s2_reg;
  logic cs_s1_reg;
  logic cs_s2_reg;
  logic link_cmd_evt;

  // first stage feeds only the second stage
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cmd_s1_reg <= 1'b0;
      cmd_s2_reg <= 1'b0;
      cmd_s3_reg <= 1'b0;
    end else begin
      cmd_s1_reg <= rx_tgl_reg;
      cmd_s2_reg <= cmd_s1_reg;
      cmd_s3_reg <= cmd_s2_reg;
    end
  end

  // strap pins are tracked through reset, so their level is ready at release
  always_ff @(posedge core_clk_in) begin
    boot_s1_reg <= boot_pin_in;
    boot_s2_reg <= boot_s1_reg;
    cs_s1_reg <= chip_select_n_in;
    cs_s2_reg <= cs_s1_reg;
  end

  assign link_cmd_evt = cmd_s2_reg ^ cmd_s3_reg;

  // ----------------------------------------------------------------------
  // debug interrupt and monitor state
  // ----------------------------------------------------------------------
  dbc_pkg::dbc_state_e state_reg;
  logic dbg_en_reg;
  logic take_irq;

  // global maskable enable plays no part here: this path is non-maskable
  assign take_irq = dbg_en_reg && (state_reg == dbc_pkg::DBC_RUN)
                    && (link_cmd_evt || trap_exec_in);

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_reg <= dbc_pkg::DBC_RUN;
    end else begin
      unique case (state_reg)
        dbc_pkg::DBC_RUN: begin
          if (take_irq) begin
            state_reg <= dbc_pkg::DBC_MON;
          end
        end
        dbc_pkg::DBC_MON: begin
          if (interrupt_return_op_in) begin
            state_reg <= dbc_pkg::DBC_RUN;
          end
        end
        default: state_reg <= dbc_pkg::DBC_RUN;
      endcase
    end
  end

  // taking the interrupt beats a same-cycle software write to the enable
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      dbg_en_reg <= dbc_pkg::DBG_EN_RST;
    end else if (take_irq) begin
      dbg_en_reg <= 1'b0;
    end else if (interrupt_return_op_in) begin
      dbg_en_reg <= 1'b1;
    end else if (ctrl_wr_in) begin
      dbg_en_reg <= ctrl_wr_data_in[dbc_pkg::CTRL_DBG_EN_BIT];
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      debug_irq_out <= 1'b0;
    end else begin
      debug_irq_out <= take_irq;
    end
  end

  assign debug_irq_enable_out = dbg_en_reg;
  assign in_monitor_out = (state_reg == dbc_pkg::DBC_MON);

  // ----------------------------------------------------------------------
  // command mailbox polled by the monitor
  // ----------------------------------------------------------------------
  // the entry command is kept too, so the monitor finds it on its first poll
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cmd_valid_out <= 1'b0;
      cmd_data_out <= dbc_pkg::WORD_ZERO;
      run_cmd_out <= 1'b0;
    end else begin
      run_cmd_out <= 1'b0;
      if (link_cmd_evt && (take_irq || state_reg == dbc_pkg::DBC_MON)) begin
        cmd_valid_out <= 1'b1;
        cmd_data_out <= rx_word_reg;
        run_cmd_out <= (rx_word_reg == dbc_pkg::CMD_RUN);
      end else if (cmd_take_in) begin
        cmd_valid_out <= 1'b0;
      end
    end
  end

  // reply word waits here while its toggle crosses to the link side
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      reply_hold_reg <= dbc_pkg::WORD_ZERO;
      reply_tgl_reg <= 1'b0;
    end else if (reply_wr_in) begin
      reply_hold_reg <= reply_data_in;
      reply_tgl_reg <= ~reply_tgl_reg;
    end
  end

  // ----------------------------------------------------------------------
  // monitor data area guard
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mon_area_hit_out <= 1'b0;
    end else begin
      mon_area_hit_out <= dmem_access_in && (state_reg == dbc_pkg::DBC_RUN)
                          && (dmem_addr_in >= dbc_pkg::MON_BASE);
    end
  end

  // ----------------------------------------------------------------------
  // reset release, boot and port format
  // ----------------------------------------------------------------------
  logic rel_reg;

  // straps are caught on the first clocked edge after release
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rel_reg <= 1'b0;
      boot_active_out <= 1'b0;
      port_format_bit_out <= dbc_pkg::FMT_TWO_WIRE;
    end else begin
      rel_reg <= 1'b1;
      if (!rel_reg) begin
        boot_active_out <= boot_s2_reg;
        port_format_bit_out <= cs_s2_reg ? dbc_pkg::FMT_SPI
                                         : dbc_pkg::FMT_TWO_WIRE;
      end else begin
        if (boot_done_in) begin
          boot_active_out <= 1'b0;
        end
        if (format_wr_in) begin
          port_format_bit_out <= format_data_in;
        end
      end
    end
  end

  // ports stay off and dac muted through reset, then run one edge later
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tx_enable_out <= 1'b0;
      scp_enable_out <= 1'b0;
      alternate_clock_input_enable_out <= 1'b0;
      dac_mute_out <= 1'b1;
      dac_recal_out <= 1'b0;
    end else begin
      tx_enable_out <= 1'b1;
      scp_enable_out <= 1'b1;
      alternate_clock_input_enable_out <= 1'b1;
      dac_mute_out <= 1'b0;
      dac_recal_out <= !rel_reg;
    end
  end

  // maskable lines are blocked while booting and on the strap capture edge
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      maskable_irq_out <= 4'h0;
    end else begin
      maskable_irq_out <= (global_maskable_irq_enable_in && rel_reg && !boot_active_out)
                          ? irq_lines_in : 4'h0;
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);

  sequence trap_while_enabled;
    trap_exec_in && dbg_en_reg && state_reg == dbc_pkg::DBC_RUN;
  endsequence
  sequence enters_monitor;
    debug_irq_out && in_monitor_out && !dbg_en_reg;
  endsequence

  trap_enters_mon_a: assert property (trap_while_enabled |=> enters_monitor)
    else $error("trap did not enter monitor");
  link_enters_mon_a: assert property (link_cmd_evt && dbg_en_reg && !in_monitor_out
    |=> in_monitor_out && cmd_valid_out)
    else $error("link command did not enter monitor");
  drop_disabled_a: assert property (!dbg_en_reg |=> !debug_irq_out)
    else $error("debug irq taken while disabled");
  rti_sets_en_a: assert property (in_monitor_out && interrupt_return_op_in
    |=> dbg_en_reg && !in_monitor_out)
    else $error("return did not restore enable");
  ctrl_wr_en_a: assert property (ctrl_wr_in && !take_irq && !interrupt_return_op_in
    |=> dbg_en_reg == $past(ctrl_wr_data_in[dbc_pkg::CTRL_DBG_EN_BIT]))
    else $error("control write missed enable");
  mon_cmd_poll_a: assert property (in_monitor_out && link_cmd_evt
    |=> cmd_valid_out && cmd_data_out == $past(rx_word_reg))
    else $error("monitor command not offered");
  boot_masks_a: assert property (boot_active_out |=> maskable_irq_out == 4'h0)
    else $error("maskable irq during boot");
  mon_area_a: assert property (dmem_access_in && !in_monitor_out
    && dmem_addr_in >= dbc_pkg::MON_BASE |=> mon_area_hit_out)
    else $error("monitor area access not flagged");
  recal_once_a: assert property (dac_recal_out |=> !dac_recal_out && !dac_mute_out)
    else $error("dac recal not single");
  run_cmd_a: assert property (run_cmd_out |-> cmd_data_out == dbc_pkg::CMD_RUN)
    else $error("run pulse without run command");
endmodule

// ---- testbench/dbc_core_tb_top.sv ----
// self-checking bench for the debug interrupt and reset/boot control block
`timescale 1ns/1ps
module dbc_core_tb_top;
  // ----------------------------------------------------------------
  // stimulus and instances
  // ----------------------------------------------------------------
  localparam logic [7:0] S_TRAP = 8'h01;
  localparam logic [7:0] S_IRET = 8'h02;
  localparam logic [7:0] S_CTRL = 8'h04;
  localparam logic [7:0] S_TAKE = 8'h08;
  localparam logic [7:0] S_REPLY = 8'h10;
  localparam logic [7:0] S_DMEM = 8'h20;
  localparam logic [7:0] S_BDONE = 8'h40;
  localparam logic [7:0] S_FMT = 8'h80;
  logic core_clk = 1'b0;
  logic rst_n = 1'b1; // falls at the first edge so the link side sees a reset edge too
  logic [7:0] stb = 8'h00;
  logic [23:0] pay = 24'h000000;
  logic gmask_en = 1'b0;
  logic [3:0] irq_lines = 4'h0;
  logic boot_pin = 1'b0;
  logic chip_sel_n = 1'b0;
  logic link_clk, host_data, dev_data, dev_oe, dbg_irq, dbg_en, in_mon, cmd_valid, run_cmd;
  logic mon_hit, boot_act, fmt, tx_en, scp_en, alt_en, mute, recal;
  logic [7:0] cmd_data;
  logic [3:0] mirq;
  int errors = 0;
  int checked = 0;
  int irq_cnt = 0;
  int run_cnt = 0;
  // core clock, 10 ns period
  always #5 core_clk = ~core_clk;
  // count one-cycle pulses so none is missed between looks
  always @(posedge core_clk) begin
    if (dbg_irq === 1'b1) irq_cnt++;
    if (run_cmd === 1'b1) run_cnt++;
  end
  dbc_host_model dbc_host_model_i (
    .link_clk_out(link_clk),
    .link_data_out(host_data),
    .dev_data_in(dev_data),
    .dev_oe_in(dev_oe)
  );
  // the data wire follows the device while it drives, the host otherwise
  dbc_core dbc_core_i (
    .core_clk_in(core_clk),
    .rst_n_in(rst_n),
    .debug_link_clock_in(link_clk),
    .debug_link_data_in(dev_oe === 1'b1 ? dev_data : host_data),
    .debug_link_data_out(dev_data),
    .debug_link_data_oe_out(dev_oe),
    .trap_exec_in(stb[0]),
    .interrupt_return_op_in(stb[1]),
    .ctrl_wr_in(stb[2]),
    .ctrl_wr_data_in(pay),
    .global_maskable_irq_enable_in(gmask_en),
    .irq_lines_in(irq_lines),
    .cmd_take_in(stb[3]),
    .reply_wr_in(stb[4]),
    .reply_data_in(pay[7:0]),
    .dmem_access_in(stb[5]),
    .dmem_addr_in(pay[11:0]),
    .boot_pin_in(boot_pin),
    .chip_select_n_in(chip_sel_n),
    .boot_done_in(stb[6]),
    .format_wr_in(stb[7]),
    .format_data_in(pay[0]),
    .debug_irq_out(dbg_irq),
    .debug_irq_enable_out(dbg_en),
    .in_monitor_out(in_mon),
    .cmd_valid_out(cmd_valid),
    .cmd_data_out(cmd_data),
    .run_cmd_out(run_cmd),
    .maskable_irq_out(mirq),
    .mon_area_hit_out(mon_hit),
    .boot_active_out(boot_act),
    .port_format_bit_out(fmt),
    .tx_enable_out(tx_en),
    .scp_enable_out(scp_en),
    .alternate_clock_input_enable_out(alt_en),
    .dac_mute_out(mute),
    .dac_recal_out(recal)
  );
  // ----------------------------------------------------------------
  // helpers and closing
  // ----------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  // one-cycle strobes with payload; looks land after the sampling edge
  task automatic fire(input logic [7:0] s, input logic [23:0] d);
    @(posedge core_clk);
    stb <= s;
    pay <= d;
    @(posedge core_clk);
    stb <= 8'h00;
    #1;
  endtask
  task automatic wait_cmd();
    for (int n = 0; n < 20 && cmd_valid !== 1'b1; n++) @(posedge core_clk);
    #1;
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic do_reset(input logic cs_lvl, input logic boot_lvl);
    @(posedge core_clk);
    rst_n <= 1'b0;
    chip_sel_n <= cs_lvl;
    boot_pin <= boot_lvl;
    repeat (8) @(posedge core_clk);
    #1;
    check({tx_en, scp_en, alt_en, in_mon, mirq}, 8'h00, "ports in reset");
    check({3'h0, mute, cmd_valid, boot_act, fmt, recal}, 8'h10, "mute in reset");
    check({4'h0, dbg_en, dbg_irq, mon_hit, run_cmd}, 8'h08, "enable in reset");
    @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    #1;
    check({3'h0, recal, mute, tx_en, scp_en, alt_en}, 8'h17, "resume");
    check({6'h00, boot_act, fmt}, {6'h00, boot_lvl, cs_lvl}, "pins");
    @(posedge core_clk);
    #1;
    check(8'(recal), 8'h00, "recal pulse");
  endtask
  // trap with the maskable enable off, nested trap dropped, return
  task automatic test_trap();
    fire(S_TRAP, 24'h000000);
    check({5'h00, dbg_irq, in_mon, dbg_en}, 8'h06, "trap");
    fire(S_TRAP, 24'h000000);
    check(8'(dbg_irq), 8'h00, "nested trap");
    fire(S_IRET, 24'h000000);
    check({6'h00, in_mon, dbg_en}, 8'h01, "return");
  endtask
  // software clears the enable: trap and link command are both dropped
  task automatic test_enable();
    fire(S_CTRL, 24'hFFFDFF);
    check(8'(dbg_en), 8'h00, "enable clear");
    fire(S_TRAP, 24'h000000);
    check({6'h00, dbg_irq, in_mon}, 8'h00, "trap gated");
    dbc_host_model_i.send_byte(8'h5A);
    repeat (6) @(posedge core_clk);
    #1;
    check({6'h00, cmd_valid, in_mon}, 8'h00, "link gated");
    fire(S_CTRL, 24'h000200);
    check(8'(dbg_en), 8'h01, "enable set");
  endtask
  task automatic test_link();
    logic [7:0] rb;
    int nb;
    int c0;
    int r0;
    logic oe_end;
    c0 = irq_cnt;
    dbc_host_model_i.send_byte(8'hA5);
    wait_cmd();
    check({5'h00, in_mon, cmd_valid, dbg_en}, 8'h06, "link entry");
    check(cmd_data, 8'hA5, "command");
    check(8'(irq_cnt - c0), 8'h01, "one entry");
    fire(S_TAKE, 24'h000000);
    check(8'(cmd_valid), 8'h00, "taken");
    r0 = run_cnt;
    dbc_host_model_i.send_byte(dbc_pkg::CMD_RUN);
    wait_cmd();
    check(cmd_data, dbc_pkg::CMD_RUN, "run code");
    check(8'(run_cnt - r0), 8'h01, "run pulse");
    check(8'(irq_cnt - c0), 8'h01, "no nesting");
    fire(S_REPLY, 24'h00003C);
    dbc_host_model_i.recv_byte(rb, nb, oe_end);
    check(rb, 8'h3C, "reply");
    check({7'h00, oe_end}, 8'h00, "oe release");
    check(8'(nb), 8'h08, "reply bits");
    fire(S_TAKE, 24'h000000);
    fire(S_IRET, 24'h000000);
    fire(S_TRAP, 24'h000000); // host planted the trap, then ran
    check({6'h00, dbg_irq, in_mon}, 8'h03, "breakpoint");
    fire(S_IRET, 24'h000000);
  endtask
  task automatic test_boot();
    do_reset(1'b1, 1'b1);
    @(posedge core_clk);
    gmask_en <= 1'b1;
    irq_lines <= 4'hA;
    repeat (3) @(posedge core_clk);
    #1;
    check({4'h0, mirq}, 8'h00, "irq in boot");
    dbc_host_model_i.send_byte(8'h33);
    wait_cmd();
    check({6'h00, in_mon, cmd_valid}, 8'h03, "boot entry");
    fire(S_TAKE, 24'h000000);
    fire(S_IRET, 24'h000000);
    fire(S_BDONE, 24'h000000);
    check(8'(boot_act), 8'h00, "boot end");
    fire(S_FMT, 24'h000000);
    check({fmt, 3'h0, mirq}, 8'h0A, "format, irq");
    fire(S_DMEM, 24'h000FDF);
    check(8'(mon_hit), 8'h00, "below area");
    fire(S_DMEM, 24'h000FE0);
    check(8'(mon_hit), 8'h01, "area base");
    fire(S_DMEM, 24'h000FFF);
    check(8'(mon_hit), 8'h01, "area top");
  endtask
  // main sequence
  initial begin
    do_reset(1'b0, 1'b0);
    test_trap();
    test_enable();
    test_link();
    test_boot();
    stop_test();
  end
  // watchdog, well beyond the expected run of some 8 us
  initial begin
    #200000;
    errors++;
    stop_test();
  end
endmodule

// ---- testbench/dbc_host_model.sv ----
// debug host model driving the serial debug link
`timescale 1ns/1ps
module dbc_host_model (
  output logic link_clk_out,
  output logic link_data_out,
  input wire logic dev_data_in,
  input wire logic dev_oe_in
);
  // link clock stands low between frames
  initial begin
    link_clk_out = 1'b0;
    link_data_out = 1'b0;
  end
  // one 160 ns link period, rising edge 40 ns in
  task automatic pulse_clk();
    #40 link_clk_out = 1'b1;
    #80 link_clk_out = 1'b0;
  endtask
  // word goes out msb first, each bit held well across its rising edge
  task automatic send_byte(input logic [7:0] b);
    #7;
    for (int i = 7; i >= 0; i--) begin
      link_data_out = b[i];
      pulse_clk();
      #40;
    end
    link_data_out = ~b[0]; // released line must not show a stale bit
  endtask
  // reply bits taken on the falling edge, only while the device drives
  task automatic recv_byte(output logic [7:0] b, output int nb, output logic oe_end);
    b = 8'h00;
    nb = 0;
    #3;
    for (int e = 0; e < 14 && nb < 8; e++) begin
      pulse_clk();
      if (dev_oe_in === 1'b1) begin
        b = {b[6:0], dev_data_in};
        nb++;
      end
      #40;
    end
    pulse_clk();
    oe_end = dev_oe_in;
  endtask
endmodule
